// [rtl/dccl_pkg.sv]
package dccl_pkg;

	// ****************************************************************
	// bank addresses
	// ****************************************************************
	localparam logic [2:0] ADDR_A_STATIC0 = 3'h0;
	localparam logic [2:0] ADDR_A_STATIC1 = 3'h1;
	localparam logic [2:0] ADDR_A_DYNAMIC = 3'h2;
	localparam logic [2:0] ADDR_TEST0     = 3'h3;
	localparam logic [2:0] ADDR_TEST1     = 3'h4;
	localparam logic [2:0] ADDR_B_STATIC0 = 3'h5;
	localparam logic [2:0] ADDR_B_STATIC1 = 3'h6;
	localparam logic [2:0] ADDR_B_DYNAMIC = 3'h7;

	// ****************************************************************
	// reset values of the banks
	// ****************************************************************
	localparam logic [3:0] RST_STATIC0    = 4'hF;
	localparam logic [3:0] RST_STATIC1    = 4'h6;
	localparam logic [3:0] RST_DYNAMIC    = 4'h9;
	localparam logic [3:0] RST_TEST       = 4'h0;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int BIT_PLL_MULT           = 0;
	localparam int BIT_CLK_SEL            = 1;
	localparam int BIT_RECENTRE           = 0;
	localparam int BIT_PRIMARY_EN         = 1;
	localparam int BIT_SECONDARY_EN       = 2;
	localparam int BIT_PATGEN_DIS         = 3;

	// phase error threshold: drift counted in tx input clock edges
	localparam logic [3:0] DRIFT_LIMIT    = 4'h8;

endpackage

// [rtl/dccl_recentre_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// recentre request synchronised into the i_clk domain for one channel
// ****************************************************************
module dccl_recentre_sync
(
	input  wire logic i_clk,
	input  wire logic i_rstn,
	input  wire logic i_req,
	output logic      o_pulse
);

	logic meta;
	logic sync;
	logic seen;

	// two flops, then an edge detect on the stable copy
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			meta   <= 1'b0;
			sync   <= 1'b0;
			seen   <= 1'b0;
			o_pulse <= 1'b0;
		end
		else
		begin
			meta    <= i_req;
			sync    <= meta;
			seen    <= sync;
			o_pulse <= sync & ~seen;
		end
	end

endmodule // dccl_recentre_sync

`default_nettype wire

// [rtl/dccl_config_latches.sv]
`timescale 1ns/1ps
`default_nettype none

module dccl_config_latches
(
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_cfg_write_strobe_n,
	input  wire logic [2:0] i_addr,
	input  wire logic [3:0] i_data,
	input  wire logic       i_tx_input_clock_a,
	input  wire logic       i_tx_input_clock_b,
	input  wire logic       i_reference_clock_a,
	input  wire logic       i_reference_clock_b,
	output logic            o_input_clock_select_a,
	output logic            o_input_clock_select_b,
	output logic            o_pll_multiplier_select_a,
	output logic            o_pll_multiplier_select_b,
	output logic            o_dual_edge_capture_a,
	output logic            o_dual_edge_capture_b,
	output logic            o_phase_buffer_bypass_a,
	output logic            o_phase_buffer_bypass_b,
	output logic            o_pattern_gen_disable_a,
	output logic            o_pattern_gen_disable_b,
	output logic            o_primary_driver_enable_a,
	output logic            o_primary_driver_enable_b,
	output logic            o_secondary_driver_enable_a,
	output logic            o_secondary_driver_enable_b,
	output logic            o_channel_power_down_a,
	output logic            o_channel_power_down_b,
	output logic            o_phase_buffer_recentre_a,
	output logic            o_phase_buffer_recentre_b,
	output logic            o_phase_buffer_error_a,
	output logic            o_phase_buffer_error_b
);

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic       strobe_n_meta;
	logic       strobe_n_sync;
	logic [2:0] addr_meta;
	logic [2:0] addr_sync;
	logic [3:0] data_meta;
	logic [3:0] data_sync;
	logic [1:0] txclk_meta;
	logic [1:0] txclk_sync;
	logic [1:0] txclk_prev;
	logic [1:0] refclk_meta;
	logic [1:0] refclk_sync;
	logic [1:0] refclk_prev;

	// every pin passes two flops; address and data assumed stable under the strobe
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			strobe_n_meta <= 1'b1;
			strobe_n_sync <= 1'b1;
			addr_meta     <= 3'h0;
			addr_sync     <= 3'h0;
			data_meta     <= 4'h0;
			data_sync     <= 4'h0;
			txclk_meta    <= 2'h0;
			txclk_sync    <= 2'h0;
			txclk_prev    <= 2'h0;
			refclk_meta   <= 2'h0;
			refclk_sync   <= 2'h0;
			refclk_prev   <= 2'h0;
		end
		else
		begin
			strobe_n_meta <= i_cfg_write_strobe_n;
			strobe_n_sync <= strobe_n_meta;
			addr_meta     <= i_addr;
			addr_sync     <= addr_meta;
			data_meta     <= i_data;
			data_sync     <= data_meta;
			txclk_meta    <= {i_tx_input_clock_b, i_tx_input_clock_a};
			txclk_sync    <= txclk_meta;
			txclk_prev    <= txclk_sync;
			refclk_meta   <= {i_reference_clock_b, i_reference_clock_a};
			refclk_sync   <= refclk_meta;
			refclk_prev   <= refclk_sync;
		end
	end

	// ****************************************************************
	// bank storage
	// ****************************************************************
	logic [3:0] bank [0:7];
	logic       write_en;
	logic [1:0] recentre_done;

	// level-sensitive store: the bank follows data while the strobe is low
	assign write_en = ~strobe_n_sync;

	function automatic logic [3:0] dccl_reset_value(input logic [2:0] a);
		case (a)
			dccl_pkg::ADDR_A_STATIC0, dccl_pkg::ADDR_B_STATIC0:
				dccl_reset_value = dccl_pkg::RST_STATIC0;
			dccl_pkg::ADDR_A_STATIC1, dccl_pkg::ADDR_B_STATIC1:
				dccl_reset_value = dccl_pkg::RST_STATIC1;
			dccl_pkg::ADDR_A_DYNAMIC, dccl_pkg::ADDR_B_DYNAMIC:
				dccl_reset_value = dccl_pkg::RST_DYNAMIC;
			default:
				dccl_reset_value = dccl_pkg::RST_TEST;
		endcase
	endfunction

	function automatic logic dccl_is_dynamic(input logic [2:0] a);
		dccl_is_dynamic = (a == dccl_pkg::ADDR_A_DYNAMIC) || (a == dccl_pkg::ADDR_B_DYNAMIC);
	endfunction

	// one bank per address; test banks 3 and 4 exist but drive nothing here
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_bank
			localparam logic [2:0] ADDR = 3'(g);
			localparam logic       CH   = (ADDR > dccl_pkg::ADDR_TEST0);
			logic hit;
			assign hit = write_en && (addr_sync == ADDR);
			always_ff @(posedge i_clk or negedge i_rstn)
			begin
				if (!i_rstn)
					bank[g] <= dccl_reset_value(ADDR);
				else if (hit)
					bank[g] <= data_sync;
				else if (dccl_is_dynamic(ADDR) && recentre_done[CH])
					bank[g][dccl_pkg::BIT_RECENTRE] <= 1'b1;
			end
		end
	endgenerate

	// ****************************************************************
	// per-channel decoding
	// ****************************************************************
	logic [3:0] stat1   [0:1];
	logic [3:0] dyn     [0:1];
	logic [1:0] clk_sel;
	logic [1:0] mult;
	logic [1:0] dual_edge;
	logic [1:0] pri_en;
	logic [1:0] sec_en;
	logic [1:0] pwr_dn;
	logic [1:0] recentre_req;

	assign stat1[0] = bank[dccl_pkg::ADDR_A_STATIC1];
	assign stat1[1] = bank[dccl_pkg::ADDR_B_STATIC1];
	assign dyn[0]   = bank[dccl_pkg::ADDR_A_DYNAMIC];
	assign dyn[1]   = bank[dccl_pkg::ADDR_B_DYNAMIC];

	generate
		for (g = 0; g < 2; g++)
		begin : g_dec
			assign clk_sel[g]   = stat1[g][dccl_pkg::BIT_CLK_SEL];
			assign mult[g]      = stat1[g][dccl_pkg::BIT_PLL_MULT];
			assign dual_edge[g] = clk_sel[g] & mult[g];
			assign pri_en[g]    = dyn[g][dccl_pkg::BIT_PRIMARY_EN];
			assign sec_en[g]    = dyn[g][dccl_pkg::BIT_SECONDARY_EN];
			assign pwr_dn[g]    = ~pri_en[g] & ~sec_en[g];
			// active-low latch: a zero asks for a recentre
			assign recentre_req[g] = ~dyn[g][dccl_pkg::BIT_RECENTRE];
		end
	endgenerate

	// ****************************************************************
	// recentre crossing and phase watch
	// ****************************************************************
	logic [1:0] txclk_rise;
	logic [1:0] refclk_rise;
	logic [1:0] recentre_pulse;
	logic [3:0] drift   [0:1];
	logic [1:0] phase_err;

	assign txclk_rise  = txclk_sync & ~txclk_prev;
	assign refclk_rise = refclk_sync & ~refclk_prev;

	generate
		for (g = 0; g < 2; g++)
		begin : g_chan
			// the tx clock seen here is sampled, so edges are coarse at best
			dccl_recentre_sync u_sync
			(
				.i_clk   (i_clk),
				.i_rstn  (i_rstn),
				.i_req   (recentre_req[g] & txclk_rise[g]),
				.o_pulse (recentre_pulse[g])
			);

			// drift counter: tx edges minus reference edges, error if too far
			always_ff @(posedge i_clk or negedge i_rstn)
			begin
				if (!i_rstn)
				begin
					drift[g]         <= 4'h0;
					phase_err[g]     <= 1'b0;
					recentre_done[g] <= 1'b0;
				end
				else
				begin
					recentre_done[g] <= recentre_pulse[g];
					if (recentre_pulse[g])
					begin
						drift[g]     <= 4'h0;
						phase_err[g] <= 1'b0;
					end
					else
					begin
						if (txclk_rise[g] && !refclk_rise[g])
							drift[g] <= drift[g] + 4'h1;
						else if (refclk_rise[g] && !txclk_rise[g])
							drift[g] <= drift[g] - 4'h1;
						// bypassed buffer cannot overflow; error holds until a recentre pulse clears it
						if (!clk_sel[g] && !pwr_dn[g] &&
							(drift[g] == dccl_pkg::DRIFT_LIMIT ||
							 drift[g] == 4'h0 - dccl_pkg::DRIFT_LIMIT))
							phase_err[g] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// ****************************************************************
	// registered outputs
	// ****************************************************************
	// reset forces drivers off before any bank is consulted
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_input_clock_select_a      <= 1'b1;
			o_input_clock_select_b      <= 1'b1;
			o_pll_multiplier_select_a   <= 1'b0;
			o_pll_multiplier_select_b   <= 1'b0;
			o_dual_edge_capture_a       <= 1'b0;
			o_dual_edge_capture_b       <= 1'b0;
			o_phase_buffer_bypass_a     <= 1'b1;
			o_phase_buffer_bypass_b     <= 1'b1;
			o_pattern_gen_disable_a     <= 1'b1;
			o_pattern_gen_disable_b     <= 1'b1;
			o_primary_driver_enable_a   <= 1'b0;
			o_primary_driver_enable_b   <= 1'b0;
			o_secondary_driver_enable_a <= 1'b0;
			o_secondary_driver_enable_b <= 1'b0;
			o_channel_power_down_a      <= 1'b1;
			o_channel_power_down_b      <= 1'b1;
			o_phase_buffer_recentre_a   <= 1'b0;
			o_phase_buffer_recentre_b   <= 1'b0;
			o_phase_buffer_error_a      <= 1'b0;
			o_phase_buffer_error_b      <= 1'b0;
		end
		else
		begin
			o_input_clock_select_a      <= clk_sel[0];
			o_input_clock_select_b      <= clk_sel[1];
			o_pll_multiplier_select_a   <= mult[0];
			o_pll_multiplier_select_b   <= mult[1];
			o_dual_edge_capture_a       <= dual_edge[0];
			o_dual_edge_capture_b       <= dual_edge[1];
			o_phase_buffer_bypass_a     <= clk_sel[0];
			o_phase_buffer_bypass_b     <= clk_sel[1];
			o_pattern_gen_disable_a     <= dyn[0][dccl_pkg::BIT_PATGEN_DIS];
			o_pattern_gen_disable_b     <= dyn[1][dccl_pkg::BIT_PATGEN_DIS];
			o_primary_driver_enable_a   <= pri_en[0];
			o_primary_driver_enable_b   <= pri_en[1];
			o_secondary_driver_enable_a <= sec_en[0];
			o_secondary_driver_enable_b <= sec_en[1];
			o_channel_power_down_a      <= pwr_dn[0];
			o_channel_power_down_b      <= pwr_dn[1];
			o_phase_buffer_recentre_a   <= recentre_pulse[0];
			o_phase_buffer_recentre_b   <= recentre_pulse[1];
			o_phase_buffer_error_a      <= phase_err[0];
			o_phase_buffer_error_b      <= phase_err[1];
		end
	end

endmodule // dccl_config_latches

`default_nettype wire

// [testbench/dccl_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// host side of the configuration write port
// ****************************************************************
module dccl_host_model
(
	input  wire logic  i_clk,
	output logic       o_cfg_write_strobe_n,
	output logic [2:0] o_addr,
	output logic [3:0] o_data
);
	// idle bus at time zero
	initial
	begin
		o_cfg_write_strobe_n = 1'b1;
		o_addr               = 3'h0;
		o_data               = 4'h0;
	end

	// one bank write; fixed bits forced so a caller slip never lands
	task automatic write(input logic [2:0] a, input logic [3:0] d);
		logic [3:0] v;
		v = d;
		if (a == 3'h0 || a == 3'h5)
			v[1] = 1'b0;
		if (a == 3'h1 || a == 3'h6)
			v[2] = 1'b0;
		@(posedge i_clk);
		o_cfg_write_strobe_n <= 1'b0;
		o_addr               <= a;
		o_data               <= v;
		repeat (3) @(posedge i_clk);
		o_cfg_write_strobe_n <= 1'b1;
		// lines outlast the strobe sync, then show no stale value
		repeat (3) @(posedge i_clk);
		o_addr               <= ~a;
		o_data               <= ~v;
		repeat (2) @(posedge i_clk);
	endtask
endmodule // dccl_host_model

`default_nettype wire

// [testbench/dccl_config_latches_sva.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// port checker, channel a
// ****************************************************************
module dccl_config_latches_sva
(
	input wire logic       i_clk,
	input wire logic       i_rstn,
	input wire logic       i_cfg_write_strobe_n,
	input wire logic [2:0] i_addr,
	input wire logic [3:0] i_data,
	input wire logic       o_input_clock_select_a,
	input wire logic       o_pll_multiplier_select_a,
	input wire logic       o_dual_edge_capture_a,
	input wire logic       o_phase_buffer_bypass_a,
	input wire logic       o_pattern_gen_disable_a,
	input wire logic       o_primary_driver_enable_a,
	input wire logic       o_secondary_driver_enable_a,
	input wire logic       o_channel_power_down_a,
	input wire logic       o_phase_buffer_recentre_a,
	input wire logic       o_phase_buffer_error_a
);
	logic [3:0] idle_cnt;
	logic [3:0] next_idle_cnt;

	// cycles with strobe pin high, saturating; sync lag needs six
	assign next_idle_cnt = !i_cfg_write_strobe_n ? 4'h0 :
		(idle_cnt == 4'hF) ? idle_cnt : idle_cnt + 4'h1;
	always_ff @(posedge i_clk or negedge i_rstn)
		if (!i_rstn)
			idle_cnt <= 4'h0;
		else
			idle_cnt <= next_idle_cnt;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	// dynamic bank write and its landing on the driver field
	sequence s_dyn_write;
		$fell(i_cfg_write_strobe_n) && i_addr == dccl_pkg::ADDR_A_DYNAMIC;
	endsequence
	sequence s_field_lands;
		##[3:5] o_primary_driver_enable_a == i_data[1];
	endsequence

	a_write_lands: assert property (s_dyn_write |-> s_field_lands)
		else $error("primary enable missed write");
	a_fields_hold: assert property (idle_cnt >= 4'h6 |->
		$stable({o_input_clock_select_a, o_pll_multiplier_select_a,
		o_pattern_gen_disable_a, o_primary_driver_enable_a}))
		else $error("field moved without write");
	a_reset_values: assert property ($rose(i_rstn) |->
		o_input_clock_select_a && !o_pll_multiplier_select_a &&
		o_pattern_gen_disable_a && !o_primary_driver_enable_a &&
		!o_secondary_driver_enable_a && !o_phase_buffer_error_a)
		else $error("bad value after reset");
	a_bypass_sel: assert property (o_phase_buffer_bypass_a == o_input_clock_select_a)
		else $error("bypass differs from clock select");
	a_dual_edge: assert property (o_dual_edge_capture_a ==
		(o_input_clock_select_a && o_pll_multiplier_select_a))
		else $error("dual edge capture wrong");
	a_power_down: assert property (o_channel_power_down_a ==
		!(o_primary_driver_enable_a || o_secondary_driver_enable_a))
		else $error("power down wrong");
	a_pulse_single: assert property (o_phase_buffer_recentre_a |=> !o_phase_buffer_recentre_a)
		else $error("recentre pulse too long");
	a_error_clears: assert property (o_phase_buffer_recentre_a |-> ##[0:2] !o_phase_buffer_error_a)
		else $error("error not cleared");
	a_error_cause: assert property ($rose(o_phase_buffer_error_a) |->
		!o_input_clock_select_a && !o_channel_power_down_a)
		else $error("error raised while bypassed or off");
endmodule // dccl_config_latches_sva

bind dccl_config_latches dccl_config_latches_sva u_sva (.*);

`default_nettype wire

// [testbench/dccl_config_latches_tb.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// self-checking bench for the configuration latch bank
// ****************************************************************
module dccl_config_latches_tb;
	logic       clk;
	logic       rstn;
	logic       stb_n;
	logic [2:0] addr;
	logic [3:0] data;
	logic       txc     = 1'b0;
	logic       refc    = 1'b0;
	logic       tx_run  = 1'b0;
	logic       ref_run = 1'b0;
	logic [1:0] tick    = 2'h0;
	logic [1:0] sel, mult, dual, byp, pgd, pri, sec, pd, rc, err;
	int         n_errors;
	int         checks_done;
	int         n_pulse;
	logic [3:0] st1 [2];
	logic [3:0] dyn [2];

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// slow channel clocks, toggled every fourth cycle
	always @(posedge clk)
	begin
		tick <= tick + 2'h1;
		if (tick == 2'h3 && tx_run)
			txc <= ~txc;
		if (tick == 2'h3 && ref_run)
			refc <= ~refc;
		if (rc[0] === 1'b1)
			n_pulse <= n_pulse + 1;
	end

	dccl_host_model host
	(
		.i_clk(clk),
		.o_cfg_write_strobe_n(stb_n),
		.o_addr(addr),
		.o_data(data)
	);

	dccl_config_latches DUT
	(
		.i_clk(clk),
		.i_rstn(rstn),
		.i_cfg_write_strobe_n(stb_n),
		.i_addr(addr),
		.i_data(data),
		.i_tx_input_clock_a(txc),
		.i_tx_input_clock_b(txc),
		.i_reference_clock_a(refc),
		.i_reference_clock_b(refc),
		.o_input_clock_select_a(sel[0]),
		.o_input_clock_select_b(sel[1]),
		.o_pll_multiplier_select_a(mult[0]),
		.o_pll_multiplier_select_b(mult[1]),
		.o_dual_edge_capture_a(dual[0]),
		.o_dual_edge_capture_b(dual[1]),
		.o_phase_buffer_bypass_a(byp[0]),
		.o_phase_buffer_bypass_b(byp[1]),
		.o_pattern_gen_disable_a(pgd[0]),
		.o_pattern_gen_disable_b(pgd[1]),
		.o_primary_driver_enable_a(pri[0]),
		.o_primary_driver_enable_b(pri[1]),
		.o_secondary_driver_enable_a(sec[0]),
		.o_secondary_driver_enable_b(sec[1]),
		.o_channel_power_down_a(pd[0]),
		.o_channel_power_down_b(pd[1]),
		.o_phase_buffer_recentre_a(rc[0]),
		.o_phase_buffer_recentre_b(rc[1]),
		.o_phase_buffer_error_a(err[0]),
		.o_phase_buffer_error_b(err[1])
	);

	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		chk8(nm, {7'h0, e}, {7'h0, g});
	endtask

	// expected outputs of one channel from its bank values
	function automatic logic [7:0] expf(input int c);
		return {st1[c][1], st1[c][0], st1[c][1] & st1[c][0], st1[c][1],
			dyn[c][3], dyn[c][1], dyn[c][2], ~(dyn[c][1] | dyn[c][2])};
	endfunction

	task automatic fields;
		chk8("fields a", expf(0), {sel[0], mult[0], dual[0], byp[0], pgd[0], pri[0], sec[0], pd[0]});
		chk8("fields b", expf(1), {sel[1], mult[1], dual[1], byp[1], pgd[1], pri[1], sec[1], pd[1]});
	endtask

	task automatic wr(input int c, input int off, input logic [3:0] d);
		if (off == 1)
			st1[c] = d;
		if (off == 2)
			dyn[c] = d;
		host.write(c ? 3'(5 + off) : 3'(off), d);
	endtask

	task automatic do_reset;
		rstn <= 1'b0;
		repeat (6) @(posedge clk);
		chk1("drivers in reset", 1'b0, |{pri, sec});
		rstn <= 1'b1;
		st1 = '{4'h6, 4'h6};
		dyn = '{4'h9, 4'h9};
		repeat (2) @(posedge clk);
		fields;
		chk8("recentre and error", 8'h0, {4'h0, rc, err});
		$display("test reset done");
	endtask

	task automatic t_static;
		logic [3:0] v [4] = '{4'h3, 4'h2, 4'h1, 4'h0};
		for (int c = 0; c < 2; c++)
		begin
			// multiplier 1 below assumes the speed range pin is not low
			wr(c, 0, 4'hD);
			foreach (v[i])
			begin
				wr(c, 1, v[i]);
				fields;
			end
		end
		$display("test static banks done");
	endtask

	task automatic t_dynamic;
		for (int c = 0; c < 2; c++)
			for (int i = 0; i < 8; i++)
			begin
				wr(c, 2, {3'(i), 1'b1});
				fields;
			end
		host.write(3'h3, 4'hF);
		host.write(3'h4, 4'h0);
		fields;
		$display("test dynamic banks done");
	endtask

	task automatic t_recentre;
		int p0;
		tx_run <= 1'b1;
		for (int i = 0; i < 300 && err[0] !== 1'b1; i++)
			@(posedge clk);
		chk1("error after drift", 1'b1, err[0]);
		chk1("error b after drift", 1'b1, err[1]);
		ref_run <= 1'b1;
		p0 = n_pulse;
		wr(0, 2, 4'hE);
		for (int i = 0; i < 100 && n_pulse == p0; i++)
			@(posedge clk);
		repeat (40) @(posedge clk);
		chk1("one recentre pulse", 1'b1, n_pulse == p0 + 1);
		chk1("error cleared", 1'b0, err[0]);
		fields;
		$display("test recentre done");
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// main sequence in host order: reset, static, dynamic, recentre, reset
	initial
	begin
		rstn = 1'b0;
		do_reset;
		t_static;
		t_dynamic;
		t_recentre;
		do_reset;
		final_report;
	end

	// hang guard, far beyond the several hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		final_report;
	end
endmodule // dccl_config_latches_tb

`default_nettype wire
